// ==== hdl/input_ref_channel_config.sv ====
// Function
// - Bit 7 routes channel through programmable pre-divider
// - Bit 6 routes channel through fixed 8 kHz divider
// - Pre-divider select overrides fixed divider select
// - Channel owns a private leaky-bucket accumulator
// - Bits 5:4 pick one of four bucket configurations
// - Bits 3:0 give nominal source frequency code
//
// Purpose: Configuration register for input channel twelve and its path decode
// Assumes: Single 200 MHz clock, synchronous active-high reset
// Notes:   Read data valid only in the cycle after the read strobe
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module input_ref_channel_config
    import src_cfg_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic              sonet_sdh_rate_select_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   prediv_path_o,
    output logic                   fixed_eight_khz_path_o,
    output logic                   direct_path_o,
    output logic      [1:0]        activity_bucket_select_o,
    output logic      [FREQ_W-1:0] freq_code_o,
    output rate_e                  rate_o,
    output logic                   freq_reserved_o,
    output logic                   freq_mismatch_o
);
    logic [DATA_W-1:0] cfg_ff;
    logic              sel_hit;
    path_e             nxt_path;

    // Frequency field of a configuration word
    function automatic logic [FREQ_W-1:0] freq_field(input logic [DATA_W-1:0] word);
        return word[FREQ_LSB +: FREQ_W];
    endfunction : freq_field

    // Bucket field of a configuration word
    function automatic logic [1:0] bucket_field(input logic [DATA_W-1:0] word);
        return word[BUCKET_LSB +: 2];
    endfunction : bucket_field

    // Address decode for the single register
    assign sel_hit = (addr_i == SRC_CFG_OFFSET);

    // Configuration storage
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cfg_ff <= SRC_CFG_RESET;
        end else if (wr_i && sel_hit) begin
            cfg_ff <= wdata_i;
        end
    end

    // Read port, unmapped addresses read zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= sel_hit ? cfg_ff : '0;
        end else begin
            rdata_o <= '0;
        end
    end

    // Path choice with pre-divider taking priority
    always_comb begin
        if (cfg_ff[PREDIV_SEL_BIT]) begin
            nxt_path = PATH_PREDIV;
        end else if (cfg_ff[FIXED_8K_SEL_BIT]) begin
            nxt_path = PATH_FIXED_8K;
        end else begin
            nxt_path = PATH_DIRECT;
        end
    end

    // Registered path steering to loop and monitor
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prediv_path_o          <= 1'b0;
            fixed_eight_khz_path_o <= 1'b0;
            direct_path_o          <= 1'b1;
        end else begin
            prediv_path_o          <= (nxt_path == PATH_PREDIV);
            fixed_eight_khz_path_o <= (nxt_path == PATH_FIXED_8K);
            direct_path_o          <= (nxt_path == PATH_DIRECT);
        end
    end

    // Bucket choice for this channel's own accumulator
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            activity_bucket_select_o <= bucket_field(SRC_CFG_RESET);
        end else begin
            activity_bucket_select_o <= bucket_field(cfg_ff);
        end
    end

    // Frequency field and advisory mismatch flag
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            freq_code_o     <= freq_field(SRC_CFG_RESET);
            freq_mismatch_o <= 1'b0;
        end else begin
            freq_code_o     <= freq_field(cfg_ff);
            freq_mismatch_o <= cfg_ff[PREDIV_SEL_BIT]
                               && (freq_field(cfg_ff) != FREQ_8K);
        end
    end

    // Rate decode of the frequency field
    freq_code_decode u_decode (
        .sys_clk_i               (sys_clk_i),
        .reset_i                 (reset_i),
        .freq_code_i             (freq_field(cfg_ff)),
        .sonet_sdh_rate_select_i (sonet_sdh_rate_select_i),
        .rate_o                  (rate_o),
        .reserved_o              (freq_reserved_o)
    );

    // Checks
    sequence s_write_cfg;
        wr_i && sel_hit;
    endsequence

    sequence s_no_write;
        !(wr_i && sel_hit);
    endsequence

    sequence s_read_cfg;
        rd_i && sel_hit;
    endsequence

    a_prediv_wins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        cfg_ff[PREDIV_SEL_BIT] |=> prediv_path_o && !fixed_eight_khz_path_o)
        else $error("pre-divider did not take priority");

    a_fixed_path: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_ff[7:6] == 2'b01) |=> fixed_eight_khz_path_o && !direct_path_o)
        else $error("fixed 8 kHz path not selected");

    a_direct_path: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_ff[7:6] == 2'b00) |=> direct_path_o && !prediv_path_o)
        else $error("direct path not selected");

    a_one_path: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $onehot({prediv_path_o, fixed_eight_khz_path_o, direct_path_o}))
        else $error("path select not one-hot");

    a_bucket_follows: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_write_cfg |=> ##1 activity_bucket_select_o == $past(wdata_i[5:4], 2))
        else $error("bucket select did not follow write");

    a_freq_follows: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_write_cfg |=> ##1 freq_code_o == $past(wdata_i[3:0], 2))
        else $error("frequency code did not follow write");

    a_reserved_code: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_ff[3:0] > 4'ha) |=> freq_reserved_o && rate_o == RATE_RESERVED)
        else $error("reserved code not flagged");

    a_t1_e1_rate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_ff[3:0] == 4'h1 && sonet_sdh_rate_select_i) |=> rate_o == RATE_1544K)
        else $error("1544 kHz not chosen");

    a_cfg_readback: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_read_cfg |=> rdata_o == $past(cfg_ff))
        else $error("read data wrong");

    // Register storage and read port checks
    a_reset_value: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> cfg_ff == SRC_CFG_RESET)
        else $error("register left reset with wrong value");

    a_write_lands: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_write_cfg |=> cfg_ff == $past(wdata_i))
        else $error("write did not reach the register");

    a_foreign_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && !sel_hit) |=> $stable(cfg_ff))
        else $error("write to another address changed the register");

    a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && !sel_hit) |=> rdata_o == '0)
        else $error("unmapped read returned data");

    a_read_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_read_cfg ##1 !rd_i |=> rdata_o == '0)
        else $error("read data stood too long");

    // Path steering checks
    a_fixed_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_ff[PREDIV_SEL_BIT] && cfg_ff[FIXED_8K_SEL_BIT])
            |=> !fixed_eight_khz_path_o && !direct_path_o)
        else $error("fixed divider select not ignored");

    a_path_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_no_write |=> ##1 $stable({prediv_path_o, fixed_eight_khz_path_o, direct_path_o}))
        else $error("path changed without a write");

    // Frequency decode checks
    a_e1_rate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (freq_field(cfg_ff) == FREQ_T1_E1 && !sonet_sdh_rate_select_i)
            |=> rate_o == RATE_2048K)
        else $error("2048 kHz not chosen");

    a_listed_code: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (freq_field(cfg_ff) <= FREQ_4K) |=> !freq_reserved_o && rate_o != RATE_RESERVED)
        else $error("listed code flagged as reserved");

    a_mismatch_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_ff[PREDIV_SEL_BIT] && freq_field(cfg_ff) != FREQ_8K) |=> freq_mismatch_o)
        else $error("advisory mismatch not raised");

    a_mismatch_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!cfg_ff[PREDIV_SEL_BIT] || freq_field(cfg_ff) == FREQ_8K) |=> !freq_mismatch_o)
        else $error("advisory mismatch raised wrongly");

    // Hold checks, outputs move only two edges after a write
    a_bucket_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_no_write |=> ##1 $stable(activity_bucket_select_o))
        else $error("bucket select changed without a write");

    a_freq_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_no_write |=> ##1 $stable(freq_code_o))
        else $error("frequency code changed without a write");
endmodule : input_ref_channel_config

// ==== hdl/src_cfg_pkg.sv ====
// Purpose: Constants for the input channel twelve source configuration register
// Assumes: 8-bit register reached over a plain address/strobe port
// Notes:   Offsets, field positions and codes named once here
package src_cfg_pkg;
    localparam int          ADDR_W             = 8;
    localparam int          DATA_W             = 8;
    localparam logic [7:0]  SRC_CFG_OFFSET     = 8'h2b;
    localparam logic [7:0]  SRC_CFG_RESET      = 8'h01;
    localparam int          PREDIV_SEL_BIT     = 7;
    localparam int          FIXED_8K_SEL_BIT   = 6;
    localparam int          BUCKET_LSB         = 4;
    localparam int          FREQ_LSB           = 0;
    localparam int          FREQ_W             = 4;

    // Nominal source frequency codes
    localparam logic [3:0]  FREQ_8K            = 4'h0;
    localparam logic [3:0]  FREQ_T1_E1         = 4'h1;
    localparam logic [3:0]  FREQ_6M48          = 4'h2;
    localparam logic [3:0]  FREQ_19M44         = 4'h3;
    localparam logic [3:0]  FREQ_25M92         = 4'h4;
    localparam logic [3:0]  FREQ_38M88         = 4'h5;
    localparam logic [3:0]  FREQ_51M84         = 4'h6;
    localparam logic [3:0]  FREQ_77M76         = 4'h7;
    localparam logic [3:0]  FREQ_155M52        = 4'h8;
    localparam logic [3:0]  FREQ_2K            = 4'h9;
    localparam logic [3:0]  FREQ_4K            = 4'ha;

    // Loop path choices
    typedef enum logic [1:0] {PATH_DIRECT, PATH_PREDIV, PATH_FIXED_8K} path_e;

    // Decoded nominal rate, binary coded enum
    typedef enum logic [3:0] {
        RATE_8K, RATE_1544K, RATE_2048K, RATE_6M48, RATE_19M44, RATE_25M92,
        RATE_38M88, RATE_51M84, RATE_77M76, RATE_155M52, RATE_2K, RATE_4K,
        RATE_RESERVED
    } rate_e;
endpackage : src_cfg_pkg

// ==== hdl/freq_code_decode.sv ====
// Purpose: Decode the nominal frequency code into a rate
// Assumes: Registered output, one cycle after the inputs
// Notes:   Unused codes report as reserved
`timescale 1ns/10ps
module freq_code_decode
    import src_cfg_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic [FREQ_W-1:0] freq_code_i,
    input  wire logic              sonet_sdh_rate_select_i,
    output rate_e                  rate_o,
    output logic                   reserved_o
);
    rate_e nxt_rate;

    // Map code to rate, SONET/SDH bit picks 1544 or 2048 kHz
    always_comb begin
        case (freq_code_i)
            FREQ_8K:     nxt_rate = RATE_8K;
            FREQ_T1_E1:  nxt_rate = sonet_sdh_rate_select_i ? RATE_1544K : RATE_2048K;
            FREQ_6M48:   nxt_rate = RATE_6M48;
            FREQ_19M44:  nxt_rate = RATE_19M44;
            FREQ_25M92:  nxt_rate = RATE_25M92;
            FREQ_38M88:  nxt_rate = RATE_38M88;
            FREQ_51M84:  nxt_rate = RATE_51M84;
            FREQ_77M76:  nxt_rate = RATE_77M76;
            FREQ_155M52: nxt_rate = RATE_155M52;
            FREQ_2K:     nxt_rate = RATE_2K;
            FREQ_4K:     nxt_rate = RATE_4K;
            default:     nxt_rate = RATE_RESERVED;
        endcase
    end

    // Register decoded rate
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rate_o     <= RATE_2048K;
            reserved_o <= 1'b0;
        end else begin
            rate_o     <= nxt_rate;
            reserved_o <= (nxt_rate == RATE_RESERVED);
        end
    end
endmodule : freq_code_decode

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the channel twelve source register
// Assumes: Strobes driven by non-blocking assignment after the rising edge
// Notes:   Outputs are checked after the write edge plus two output edges
`timescale 1ns/10ps
module testbench
    import src_cfg_pkg::*;
;
    logic        sys_clk_i               = 1'b0;
    logic        reset_i                 = 1'b1;
    logic [7:0]  addr_i                  = 8'h00;
    logic [7:0]  wdata_i                 = 8'h00;
    logic        wr_i                    = 1'b0;
    logic        rd_i                    = 1'b0;
    logic        sonet_sdh_rate_select_i = 1'b0;
    logic [7:0]  rdata_o;
    logic        prediv_path_o;
    logic        fixed_eight_khz_path_o;
    logic        direct_path_o;
    logic [1:0]  activity_bucket_select_o;
    logic [3:0]  freq_code_o;
    rate_e       rate_o;
    logic        freq_reserved_o;
    logic        freq_mismatch_o;
    int          n_fail                  = 0;
    int          n_compared              = 0;
    // Expected decoded rate for codes 0 to 10, code 1 fixed up per rate select
    rate_e       rtab [0:10] = '{RATE_8K, RATE_2048K, RATE_6M48, RATE_19M44, RATE_25M92,
        RATE_38M88, RATE_51M84, RATE_77M76, RATE_155M52, RATE_2K, RATE_4K};

    // 200 MHz clock
    always #2.5 sys_clk_i = ~sys_clk_i;

    input_ref_channel_config u_dut (.sys_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .sonet_sdh_rate_select_i, .rdata_o, .prediv_path_o, .fixed_eight_khz_path_o,
        .direct_path_o, .activity_bucket_select_o, .freq_code_o, .rate_o,
        .freq_reserved_o, .freq_mismatch_o);

    // Compare plain vectors
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Compare decoded rates
    task automatic chk_rate(input rate_e exp, input rate_e got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] rate expected %s seen %s", exp.name(), got.name());
        end
    endtask : chk_rate

    // One-cycle write, then let register and output flops settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask : wr

    // One-cycle read; data stands only in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk("rdata", exp, rdata_o);
        @(posedge sys_clk_i);
        #1;
        chk("rdata_idle", 8'h00, rdata_o);
    endtask : rd

    // Print counts and verdict, end the run
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        logic [7:0] d;
        repeat (10) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        chk("direct_rst", 8'h01, {7'h00, direct_path_o});
        chk_rate(RATE_2048K, rate_o);
        rd(8'h2b, 8'h01);
        for (int i = 0; i < 4; i++) begin
            d = 8'(i << 6);
            wr(8'h2b, d);
            chk("prediv", {7'h00, d[7]}, {7'h00, prediv_path_o});
            chk("fixed", {7'h00, d[6] & ~d[7]}, {7'h00, fixed_eight_khz_path_o});
            chk("direct", {7'h00, ~d[7] & ~d[6]}, {7'h00, direct_path_o});
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h2b, 8'(i << 4));
            chk("bucket", 8'(i), {6'h00, activity_bucket_select_o});
            rd(8'h2b, 8'(i << 4));
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk_i);
            sonet_sdh_rate_select_i <= s[0];
            for (int c = 0; c < 16; c++) begin
                wr(8'h2b, 8'(c));
                chk("freq_code", 8'(c), {4'h0, freq_code_o});
                chk("reserved", {7'h00, c > 10}, {7'h00, freq_reserved_o});
                chk_rate(c > 10 ? RATE_RESERVED : (c == 1 && s == 1) ? RATE_1544K
                    : rtab[c], rate_o);
            end
        end
        wr(8'h2b, 8'h81);
        chk("mismatch", 8'h01, {7'h00, freq_mismatch_o});
        wr(8'h2b, 8'hc0);
        chk("mismatch_ok", 8'h00, {7'h00, freq_mismatch_o});
        chk("fixed_ovr", 8'h00, {7'h00, fixed_eight_khz_path_o});
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h00);
        rd(8'h2b, 8'hc0);
        conclude();
    end

    // Watchdog far beyond the expected run length
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule : testbench
